// ### hw/brake_route_pkg.sv
package brake_route_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_OCW    = 8'h04;
    localparam logic [7:0] A_MCFG   = 8'h08;
    localparam logic [7:0] A_ROUTE0 = 8'h10;
    localparam logic [7:0] A_ROUTE1 = 8'h14;
    localparam logic [7:0] A_ROUTE2 = 8'h18;
    localparam logic [7:0] A_DLY1   = 8'h20;
    localparam logic [7:0] A_DLY2   = 8'h24;
    localparam logic [7:0] A_DLY3   = 8'h28;
    localparam logic [7:0] A_DLY4   = 8'h2C;
    localparam logic [7:0] A_FREQ   = 8'h30;
    localparam logic [7:0] A_DUTY   = 8'h34;
    localparam logic [7:0] A_STATUS = 8'h38;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ROUTE_EN_BIT   = 0;
    localparam int AUTO_BRAKE_BIT = 2;
    localparam int BRAKE_CMD_BIT  = 0;
    localparam int INV_BIT        = 7;
    localparam int SRC_LSB        = 8;

    // ----------------------------------------------------------------
    // reset values and route off code
    // ----------------------------------------------------------------
    localparam logic [15:0] ROUTE_RST = 16'h0FFF;
    localparam logic [15:0] ROUTE_OFF = 16'h0FFF;
    localparam logic [31:0] MCFG_RST  = 32'h0000_0004;
    localparam logic [15:0] FREQ_RST  = 16'h03E8;
    localparam logic [6:0]  DUTY_RST  = 7'h64;
    localparam logic [15:0] DLY_RST   = 16'h0000;

    // ----------------------------------------------------------------
    // source codes and limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  SRC_ONE   = 8'h00;
    localparam logic [7:0]  SRC_ZERO  = 8'h01;
    localparam logic [7:0]  SRC_ENC   = 8'h02;
    localparam logic [7:0]  SRC_ENC_L = 8'h08;
    localparam logic [7:0]  SRC_POS   = 8'h09;
    localparam logic [7:0]  SRC_POS_L = 8'h0F;
    localparam logic [7:0]  SRC_PWM   = 8'h10;
    localparam logic [7:0]  SRC_PWM_N = 8'h11;
    localparam logic [15:0] FREQ_MAX  = 16'h07D0;
    localparam logic [6:0]  DUTY_MIN  = 7'h02;
    localparam logic [6:0]  DUTY_MAX  = 7'h64;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam logic [23:0] CLK_HZ      = 24'h98_9680;
    localparam logic [23:0] DUTY_SCALE  = 24'h01_86A0;
    localparam int          CLK_PER_NS  = 32'h0000_0064;
    localparam int          SW_HALF_NS  = 32'h0003_D090;
    localparam int          OUT_HALF_NS = 32'h000F_4240;
    localparam int          MS_NS       = 32'h000F_4240;
    localparam int SW_HALF_CYC  = (SW_HALF_NS + CLK_PER_NS - 1) / CLK_PER_NS;
    localparam int OUT_HALF_CYC = (OUT_HALF_NS + CLK_PER_NS - 1) / CLK_PER_NS;
    localparam int MS_CYC       = MS_NS / CLK_PER_NS;

    // ----------------------------------------------------------------
    // brake sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_WAIT3 = 3'h1,
        ST_WAIT4 = 3'h3,
        ST_RUN   = 3'h2,
        ST_STOP  = 3'h6,
        ST_WAIT1 = 3'h7,
        ST_WAIT2 = 3'h5
    } state_e;

endpackage

// ### hw/output_routing_brake_control.sv
// Contract
// RL1: routing matrix drives outputs only while routing enable bit is 1
// RL2: route word: high byte picks source, low byte picks control bit
// RL3: route 0 feeds software pwm output, route 1 output 1, route 2 output 2
// RL4: control bit 1 switches signal on; with bit 7 set, 0 does
// RL5: route word 0FFF switches that output off
// RL6: source 00 holds output at 1, source 01 holds it at 0
// RL7: sources 02..08 give encoder pulses divided by 1..64
// RL8: sources 09..0F give position pulses divided by 1..64
// RL9: source 10 gives brake pwm, source 11 its inverse
// RL10: divider 1 gives one output pulse per increment
// RL11: software pwm output up to 2 kHz, others up to 500 Hz
// RL12: automatic mode releases brake only while operation is enabled
// RL13: motor config bit 2 selects automatic, else control word bit 0
// RL14: enable: current on, delay 3, release, delay 4, then travel
// RL15: disable: standstill, delay 1, engage, delay 2, current off
// RL16: released brake output is a pwm of settable frequency and duty
// RL17: brake pwm frequency in hertz, writes above 2000 rejected
// RL18: duty in percent 2..100, at 100 output stays on
// RL19: control word bit 0 commands the brake
// RL20: each output keeps its own divider counter
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module output_routing_brake_control #(
    parameter int unsigned OUT_HALF_CYC = brake_route_pkg::OUT_HALF_CYC,
    parameter int unsigned MS_CYC       = brake_route_pkg::MS_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enc_lsb,
    input  wire logic        pos_lsb,
    input  wire logic        op_enable_req,
    input  wire logic        standstill,
    output logic             brake_out,
    output logic             motor_current_on,
    output logic             halt_req,
    output logic             travel_en,
    output logic             out_sw_pwm,
    output logic             out_one,
    output logic             out_two
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  route_en;
        logic [31:0]           ocw;
        logic [31:0]           mcfg;
        logic [2:0][15:0]      route;
        logic [3:0][15:0]      dly;
        logic [15:0]           freq;
        logic [6:0]            duty;
        logic [2:0]            enc_s;
        logic [2:0]            pos_s;
        logic [23:0]           acc;
        logic                  pwm;
        brake_route_pkg::state_e st;
        logic [15:0]           tmr;
        logic [13:0]           pre;
        logic                  brake;
        logic                  cur;
        logic                  travel;
        logic                  halt;
        logic                  rel;
        logic [2:0][5:0]       divc;
        logic [2:0][3:0]       pend;
        logic [2:0][13:0]      dwell;
        logic [2:0]            lvl;
    } state_s;

    state_s q, d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       enc_inc;
        logic       pos_inc;
        logic       wr;
        logic       err;
        logic [7:0] src;
        logic [7:0] ctl;
        logic [2:0] k;
        logic [5:0] mask;
        logic       active;
        logic       pulse;
        logic       inc;
        logic       tgt;
        logic [13:0] dlen;
        logic [23:0] sum;
        logic       wait_done;
        logic       auto_rel;
        enc_inc   = 1'b0;
        pos_inc   = 1'b0;
        wr        = 1'b0;
        err       = 1'b0;
        src       = 8'h00;
        ctl       = 8'h00;
        k         = 3'h0;
        mask      = 6'h00;
        active    = 1'b0;
        pulse     = 1'b0;
        inc       = 1'b0;
        tgt       = 1'b0;
        dlen      = 14'h0000;
        sum       = 24'h00_0000;
        wait_done = 1'b0;
        auto_rel  = 1'b0;
        d = q;

        // pins pass two flops; third flop only for edge detect
        d.enc_s = {q.enc_s[1:0], enc_lsb};
        d.pos_s = {q.pos_s[1:0], pos_lsb};
        enc_inc = q.enc_s[2] ^ q.enc_s[1]; // [RL10]
        pos_inc = q.pos_s[2] ^ q.pos_s[1]; // [RL10]

        // ------------------------------------------------------------
        // apb slave: answer registered at end of setup phase, no wait state
        // ------------------------------------------------------------
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            case (paddr)
                brake_route_pkg::A_CTRL:   d.prdata[0] = q.route_en;
                brake_route_pkg::A_OCW:    d.prdata = q.ocw;
                brake_route_pkg::A_MCFG:   d.prdata = q.mcfg;
                brake_route_pkg::A_ROUTE0: d.prdata[15:0] = q.route[0];
                brake_route_pkg::A_ROUTE1: d.prdata[15:0] = q.route[1];
                brake_route_pkg::A_ROUTE2: d.prdata[15:0] = q.route[2];
                brake_route_pkg::A_DLY1:   d.prdata[15:0] = q.dly[0];
                brake_route_pkg::A_DLY2:   d.prdata[15:0] = q.dly[1];
                brake_route_pkg::A_DLY3:   d.prdata[15:0] = q.dly[2];
                brake_route_pkg::A_DLY4:   d.prdata[15:0] = q.dly[3];
                brake_route_pkg::A_FREQ:   d.prdata[15:0] = q.freq;
                brake_route_pkg::A_DUTY:   d.prdata[6:0] = q.duty;
                brake_route_pkg::A_STATUS: d.prdata[10:0] =
                    {q.lvl, q.pwm, q.halt, q.travel, q.cur, q.brake,
                     q.st};
                default:                   err = 1'b1;
            endcase
            if (pwrite && paddr == brake_route_pkg::A_STATUS) begin
                err = 1'b1;
            end
            if (pwrite && paddr == brake_route_pkg::A_FREQ &&
                (pwdata[31:16] != 16'h0000 ||
                 pwdata[15:0] > brake_route_pkg::FREQ_MAX ||
                 pwdata[15:0] == 16'h0000)) begin
                err = 1'b1; // [RL17]
            end
            if (pwrite && paddr == brake_route_pkg::A_DUTY &&
                (pwdata[31:7] != 25'h000_0000 ||
                 pwdata[6:0] < brake_route_pkg::DUTY_MIN ||
                 pwdata[6:0] > brake_route_pkg::DUTY_MAX)) begin
                err = 1'b1; // [RL18]
            end
            d.pslverr = err;
        end
        // refused writes store nothing
        wr = psel && penable && q.pready && pwrite && !q.pslverr;
        if (wr) begin
            case (paddr)
                brake_route_pkg::A_CTRL:
                    d.route_en = pwdata[brake_route_pkg::ROUTE_EN_BIT];
                brake_route_pkg::A_OCW:    d.ocw = pwdata;
                brake_route_pkg::A_MCFG:   d.mcfg = pwdata;
                brake_route_pkg::A_ROUTE0: d.route[0] = pwdata[15:0]; // [RL2]
                brake_route_pkg::A_ROUTE1: d.route[1] = pwdata[15:0];
                brake_route_pkg::A_ROUTE2: d.route[2] = pwdata[15:0];
                brake_route_pkg::A_DLY1:   d.dly[0] = pwdata[15:0];
                brake_route_pkg::A_DLY2:   d.dly[1] = pwdata[15:0];
                brake_route_pkg::A_DLY3:   d.dly[2] = pwdata[15:0];
                brake_route_pkg::A_DLY4:   d.dly[3] = pwdata[15:0];
                brake_route_pkg::A_FREQ:   d.freq = pwdata[15:0]; // [RL17]
                brake_route_pkg::A_DUTY:   d.duty = pwdata[6:0]; // [RL18]
                default:                   d.ocw = q.ocw;
            endcase
        end

        // ------------------------------------------------------------
        // brake pwm: phase accumulator avoids a divider
        // ------------------------------------------------------------
        sum = q.acc + {8'h00, q.freq};
        if (sum >= brake_route_pkg::CLK_HZ) begin
            sum = sum - brake_route_pkg::CLK_HZ;
        end
        d.acc = sum; // [RL16]
        d.pwm = sum < 24'(q.duty * brake_route_pkg::DUTY_SCALE); // [RL18]

        // ------------------------------------------------------------
        // brake sequencer
        // ------------------------------------------------------------
        if (q.pre == 14'h0000) begin
            d.pre = 14'(MS_CYC - 1);
            if (q.tmr != 16'h0000) begin
                d.tmr = q.tmr - 16'h0001;
            end
        end else begin
            d.pre = q.pre - 14'h0001;
        end
        wait_done = q.tmr == 16'h0000;
        case (q.st)
            brake_route_pkg::ST_OFF: begin
                if (op_enable_req) begin
                    d.st  = brake_route_pkg::ST_WAIT3; // [RL14]
                    d.tmr = q.dly[2];
                    d.pre = 14'(MS_CYC - 1);
                end
            end
            brake_route_pkg::ST_WAIT3: begin
                if (!op_enable_req) begin
                    d.st = brake_route_pkg::ST_STOP;
                end else if (wait_done) begin
                    d.st  = brake_route_pkg::ST_WAIT4; // [RL14]
                    d.tmr = q.dly[3];
                    d.pre = 14'(MS_CYC - 1);
                end
            end
            brake_route_pkg::ST_WAIT4: begin
                if (!op_enable_req) begin
                    d.st = brake_route_pkg::ST_STOP;
                end else if (wait_done) begin
                    d.st = brake_route_pkg::ST_RUN; // [RL14]
                end
            end
            brake_route_pkg::ST_RUN: begin
                if (!op_enable_req) begin
                    d.st = brake_route_pkg::ST_STOP; // [RL15]
                end
            end
            brake_route_pkg::ST_STOP: begin
                if (standstill) begin
                    d.st  = brake_route_pkg::ST_WAIT1; // [RL15]
                    d.tmr = q.dly[0];
                    d.pre = 14'(MS_CYC - 1);
                end
            end
            brake_route_pkg::ST_WAIT1: begin
                if (wait_done) begin
                    d.st  = brake_route_pkg::ST_WAIT2; // [RL15]
                    d.tmr = q.dly[1];
                    d.pre = 14'(MS_CYC - 1);
                end
            end
            brake_route_pkg::ST_WAIT2: begin
                if (wait_done) begin
                    d.st = brake_route_pkg::ST_OFF; // [RL15]
                end
            end
            default: d.st = brake_route_pkg::ST_OFF;
        endcase
        d.cur    = d.st != brake_route_pkg::ST_OFF; // [RL14] [RL15]
        d.travel = d.st == brake_route_pkg::ST_RUN; // [RL14]
        d.halt   = d.st == brake_route_pkg::ST_STOP; // [RL15]
        auto_rel = d.st == brake_route_pkg::ST_WAIT4 ||
                   d.st == brake_route_pkg::ST_RUN; // [RL12]
        // held through standstill and delay 1, only if it was released
        if (d.st == brake_route_pkg::ST_STOP ||
            d.st == brake_route_pkg::ST_WAIT1) begin
            auto_rel = q.rel; // [RL15]
        end
        d.rel = auto_rel;
        if (q.mcfg[brake_route_pkg::AUTO_BRAKE_BIT]) begin // [RL13]
            d.brake = auto_rel && d.pwm; // [RL12] [RL16]
        end else begin
            d.brake = q.ocw[brake_route_pkg::BRAKE_CMD_BIT] && d.pwm; // [RL19]
        end

        // ------------------------------------------------------------
        // routing matrix, one slice per output
        // ------------------------------------------------------------
        for (int i = 0; i < 3; i++) begin
            src   = q.route[i][15:brake_route_pkg::SRC_LSB]; // [RL2] [RL3]
            ctl   = q.route[i][7:0];
            active = q.route_en && // [RL1]
                     q.route[i] != brake_route_pkg::ROUTE_OFF && // [RL5]
                     (q.ocw[ctl[4:0]] ^ ctl[brake_route_pkg::INV_BIT]); // [RL4]
            pulse = 1'b0;
            inc   = 1'b0;
            k     = 3'h0;
            tgt   = 1'b0;
            if (src >= brake_route_pkg::SRC_ENC &&
                src <= brake_route_pkg::SRC_ENC_L) begin
                pulse = 1'b1; // [RL7]
                inc   = enc_inc;
                k     = 3'(src - brake_route_pkg::SRC_ENC);
            end else if (src >= brake_route_pkg::SRC_POS &&
                         src <= brake_route_pkg::SRC_POS_L) begin
                pulse = 1'b1; // [RL8]
                inc   = pos_inc;
                k     = 3'(src - brake_route_pkg::SRC_POS);
            end else if (src == brake_route_pkg::SRC_ONE) begin
                tgt = active; // [RL6]
            end else if (src == brake_route_pkg::SRC_PWM) begin
                tgt = active && q.pwm; // [RL9]
            end else if (src == brake_route_pkg::SRC_PWM_N) begin
                tgt = active && !q.pwm; // [RL9]
            end
            // private counter per output keeps others undisturbed
            mask = 6'((7'h01 << k) - 7'h01);
            if (!pulse || !active) begin
                d.divc[i] = 6'h00;
                d.pend[i] = 4'h0;
            end else if (inc) begin
                if ((q.divc[i] & mask) == mask) begin // [RL20]
                    d.divc[i] = 6'h00;
                    if (q.pend[i] != 4'hF) begin
                        d.pend[i] = q.pend[i] + 4'h1; // [RL10]
                    end
                end else begin
                    d.divc[i] = q.divc[i] + 6'h01; // [RL20]
                end
            end
            // each level held a minimum time, caps rate per output
            dlen = (i == 0) ? 14'(brake_route_pkg::SW_HALF_CYC - 1)
                            : 14'(OUT_HALF_CYC - 1); // [RL11]
            if (q.dwell[i] != 14'h0000) begin
                d.dwell[i] = q.dwell[i] - 14'h0001; // [RL11]
            end else if (pulse) begin
                if (q.lvl[i]) begin
                    d.lvl[i]   = 1'b0;
                    d.dwell[i] = dlen;
                end else if (d.pend[i] != 4'h0 && active) begin
                    d.lvl[i]   = 1'b1; // [RL10]
                    d.pend[i]  = d.pend[i] - 4'h1;
                    d.dwell[i] = dlen;
                end
            end else if (tgt != q.lvl[i]) begin
                d.lvl[i]   = tgt;
                d.dwell[i] = dlen;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            q.mcfg     <= brake_route_pkg::MCFG_RST;
            q.route    <= {3{brake_route_pkg::ROUTE_RST}};
            q.dly      <= {4{brake_route_pkg::DLY_RST}};
            q.freq     <= brake_route_pkg::FREQ_RST;
            q.duty     <= brake_route_pkg::DUTY_RST;
            q.st       <= brake_route_pkg::ST_OFF;
        end else begin
            q <= d;
        end
    end

    assign prdata           = q.prdata;
    assign pready           = q.pready;
    assign pslverr          = q.pslverr;
    assign brake_out        = q.brake;
    assign motor_current_on = q.cur;
    assign halt_req         = q.halt;
    assign travel_en        = q.travel;
    assign out_sw_pwm       = q.lvl[0];
    assign out_one          = q.lvl[1];
    assign out_two          = q.lvl[2];

endmodule

`default_nettype wire

// ### verification/motor_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module motor_load_model (
    input  wire logic clk,
    input  wire logic halt_req,
    output logic      standstill,
    output logic      enc_lsb,
    output logic      pos_lsb
);
    int k = 0;
    initial begin
        enc_lsb = 0;
        pos_lsb = 0;
    end
    // the motor coasts a few cycles before it reports rest
    always @(posedge clk) k <= !halt_req ? 0 : (k < 5 ? k + 1 : k);
    assign standstill = (k == 5);
    task step(input bit pos, input int cnt);
        repeat (cnt) begin
            repeat (40) @(posedge clk);
            if (pos) pos_lsb <= ~pos_lsb;
            else enc_lsb <= ~enc_lsb;
        end
    endtask
endmodule
`default_nettype wire

// ### verification/output_routing_brake_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module output_routing_brake_control_asserts #(
    parameter int unsigned OUT_HALF_CYC = 8,
    parameter int unsigned MS_CYC       = 8
) (
    input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        enc_lsb, pos_lsb, op_enable_req, standstill,
    input wire logic        brake_out, motor_current_on, halt_req, travel_en,
    input wire logic        out_sw_pwm, out_one, out_two
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mode bit shadow, one cycle late to match the registered brake
    logic [1:0] auto_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) auto_q <= 2'b11;
        else begin
            auto_q[1] <= auto_q[0];
            if (psel && penable && pready && pwrite && !pslverr
                && paddr == 8'h08) auto_q[0] <= pwdata[2];
        end
    end
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel)
        && !$past(penable)) else $error("ready without setup");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    travel_cur_a: assert property (travel_en |-> motor_current_on && !halt_req)
        else $error("travel without current");
    cur_cause_a: assert property ($rose(motor_current_on) |-> $past(op_enable_req))
        else $error("current on without request");
    halt_hold_a: assert property (halt_req && !standstill |=> halt_req)
        else $error("halt dropped before rest");
    halt_rel_a: assert property ($fell(halt_req) |-> $past(standstill))
        else $error("halt left without rest");
    auto_brake_a: assert property (auto_q[1] && !motor_current_on |-> !brake_out)
        else $error("brake released without current");
    dwell_one_a: assert property ($changed(out_one) |=> $stable(out_one)[*4])
        else $error("output one too fast");
    dwell_sw_a: assert property ($changed(out_sw_pwm) |=> $stable(out_sw_pwm)[*8])
        else $error("pwm output too fast");
endmodule
bind output_routing_brake_control output_routing_brake_control_asserts #(
    .OUT_HALF_CYC(OUT_HALF_CYC), .MS_CYC(MS_CYC)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .enc_lsb(enc_lsb), .pos_lsb(pos_lsb),
    .op_enable_req(op_enable_req), .standstill(standstill),
    .brake_out(brake_out), .motor_current_on(motor_current_on),
    .halt_req(halt_req), .travel_en(travel_en), .out_sw_pwm(out_sw_pwm),
    .out_one(out_one), .out_two(out_two));
`default_nettype wire

// ### verification/output_routing_brake_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module output_routing_brake_control_tb;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, op_req = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, brake, cur, halt, trav, o_sw, o_one, o_two, p2;
    wire logic enc, pos, still;
    wire logic [6:0] outs = {brake, cur, halt, trav, o_sw, o_one, o_two};
    int errors = 0, num_checks = 0, c1 = 0, c2 = 0, n;
    always #50 clk = ~clk;
    output_routing_brake_control #(.OUT_HALF_CYC(8), .MS_CYC(8)) u_output_routing_brake_control (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_lsb(enc), .pos_lsb(pos), .op_enable_req(op_req),
        .standstill(still), .brake_out(brake), .motor_current_on(cur),
        .halt_req(halt), .travel_en(trav), .out_sw_pwm(o_sw), .out_one(o_one),
        .out_two(o_two));
    motor_load_model u_motor_load_model (.clk(clk), .halt_req(halt),
        .standstill(still), .enc_lsb(enc), .pos_lsb(pos));
    logic p1 = 0;
    always @(posedge clk) begin
        p1 <= o_one;
        p2 <= o_two;
        if (o_one && !p1) c1++;
        if (o_two && !p2) c2++;
    end
    task close_out;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
        `CHK("pready", 1'b1, pready)
        if (pready !== 1'b1) close_out();
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
        `CHK("pslverr", ee, e)
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("prdata", x, r)
    endtask
    // bounded wait for one output level; n holds the cycles taken
    task wt(input int i, input logic v, input int lim);
        n = 0;
        while (outs[i] !== v) begin
            @(posedge clk); n++;
            if (n > lim && outs[i] !== v) begin
                `CHK("wait", v, outs[i]) close_out();
            end
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rd(8'h00, 32'h0); rd(8'h08, 32'h4); rd(8'h14, 32'h0FFF);
        wr(8'h3C, 32'h0, 1); wr(8'h38, 32'h0, 1);
        wr(8'h30, 32'd2001, 1); rd(8'h30, 32'd1000);
        wr(8'h30, 32'd2000, 0);
        wr(8'h34, 32'd1, 1); wr(8'h34, 32'd101, 1); wr(8'h34, 32'd2, 0);
        wr(8'h34, 32'd100, 0); wr(8'h04, 32'h1, 0); wr(8'h14, 32'h0, 0);
        repeat (30) @(posedge clk);
        `CHK("out_one", 1'b0, o_one)
        wr(8'h00, 32'h1, 0); wt(1, 1, 40);
        wr(8'h14, 32'h0080, 0); wt(1, 0, 40);
        wr(8'h04, 32'h0, 0); wt(1, 1, 40);
        wr(8'h14, 32'h0100, 0); wt(1, 0, 40);
        wr(8'h14, 32'h0005, 0); wr(8'h04, 32'h20, 0); wt(1, 1, 40);
        wr(8'h14, 32'h0FFF, 0); wt(1, 0, 40);
        wr(8'h10, 32'h0005, 0); wt(2, 1, 6000);
        wr(8'h18, 32'h1005, 0); wt(0, 1, 40);
        wr(8'h18, 32'h1105, 0); wt(0, 0, 40);
        wr(8'h14, 32'h0305, 0);
        for (int s = 2; s < 16; s++) begin
            wr(8'h18, {16'h0, s[7:0], 8'h05}, 0);
            repeat (20) @(posedge clk);
            c1 = 0; c2 = 0;
            u_motor_load_model.step(s > 8, 64);
            repeat (40) @(posedge clk);
            `CHK("pulses", 64 >> ((s - 2) % 7), c2)
            if (s == 2) `CHK("div2", 32, c1)
        end
        wr(8'h28, 32'h2, 0); wr(8'h2C, 32'h1, 0);
        wr(8'h20, 32'h1, 0); wr(8'h24, 32'h1, 0); wr(8'h04, 32'h1, 0);
        repeat (10) @(posedge clk);
        `CHK("brake", 1'b0, brake)
        op_req <= 1; wt(5, 1, 10); wt(6, 1, 40);
        `CHK("rel_time", 1'b1, n >= 15 && n <= 20)
        wt(3, 1, 40);
        `CHK("trav_time", 1'b1, n >= 7 && n <= 12)
        `CHK("brake", 1'b1, brake)
        op_req <= 0; wt(4, 1, 10);
        `CHK("brake_hold", 1'b1, brake)
        wt(6, 0, 60);
        `CHK("eng_time", 1'b1, n >= 12 && n <= 18)
        `CHK("current", 1'b1, cur)
        wt(5, 0, 40);
        `CHK("off_time", 1'b1, n >= 7 && n <= 12)
        wr(8'h08, 32'h0, 0); wt(6, 1, 20);
        wr(8'h04, 32'h0, 0); wt(6, 0, 20);
        wr(8'h34, 32'd50, 0); wr(8'h04, 32'h1, 0);
        wt(6, 1, 6000); wt(6, 0, 6000); wt(6, 1, 6000);
        close_out();
    end
endmodule
`default_nettype wire
